// ---- src/bpt_regs.v ----
// Port option bits, per-port delayed transaction timeouts and capability header
`timescale 1ns/1ps
`include "bpt_consts.vh"
module bpt_regs
(
   input wire clk_sys, // 250 MHz system clock
   input wire arst_n, // Asynchronous reset, active low
   input wire [`BPT_AW-1:0] reg_addr, // Register byte address
   input wire [31:0] reg_wdata, // Write data
   input wire reg_wr, // Write strobe
   input wire reg_rd, // Read strobe
   input wire serr_enable, // Allows system error reporting
   input wire pri_clk_en, // Primary PCI clock enable pulse
   input wire sec_clk_en, // Secondary PCI clock enable pulse
   input wire pri_dc_queued, // Primary delayed completion queued, pulse
   input wire pri_repeat, // Primary initiator repeated transaction, pulse
   input wire sec_dc_queued, // Secondary delayed completion queued, pulse
   input wire sec_repeat, // Secondary initiator repeated transaction, pulse
   output reg [31:0] reg_rdata, // Read data, cycle after read strobe
   output reg pri_mwi_keep, // Primary MWI forwarded unchanged
   output reg sec_mwi_keep, // Secondary MWI forwarded unchanged
   output reg long_lock_req, // Long requests for lock cycles
   output reg sec_hold_req, // Secondary master holds request
   output reg pri_hold_req, // Primary master holds request
   output reg pri_discard, // Primary queued completion discarded, pulse
   output reg sec_discard, // Secondary queued completion discarded, pulse
   output reg primary_system_error_out, // System error level
   output reg irq // Interrupt level
);
   reg [`BPT_OPT_HI:`BPT_OPT_LO] opt_r;
   // Programmed timeout limits, one per port
   reg [`BPT_TO_W-1:0] pri_to_r;
   reg [`BPT_TO_W-1:0] sec_to_r;
   // Sticky delayed transaction timeout flag and its next value
   reg dto_r;
   reg dto_nxt;
   // Interrupt status and mask, bit 0 primary, bit 1 secondary
   reg [`BPT_IRQ_W-1:0] irq_stat_r;
   reg [`BPT_IRQ_W-1:0] irq_stat_nxt;
   reg [`BPT_IRQ_W-1:0] irq_mask_r;
   // Read data before the output flop
   reg [31:0] rdata_nxt;
   // Address decode, one line per writable register
   wire hit_opt;
   wire hit_to;
   wire hit_serr;
   wire hit_istat;
   wire hit_imask;
   assign hit_opt = (reg_addr == `BPT_OFF_PORT_OPT);
   assign hit_to = (reg_addr == `BPT_OFF_TIMEOUT);
   assign hit_serr = (reg_addr == `BPT_OFF_SERR_STAT);
   assign hit_istat = (reg_addr == `BPT_OFF_IRQ_STAT);
   assign hit_imask = (reg_addr == `BPT_OFF_IRQ_MASK);
   // Write enables; reads have no side effects, so only writes are qualified
   wire wr_opt;
   wire wr_to;
   wire wr_serr;
   wire wr_istat;
   wire wr_imask;
   assign wr_opt = reg_wr && hit_opt;
   assign wr_to = reg_wr && hit_to;
   assign wr_serr = reg_wr && hit_serr;
   assign wr_istat = reg_wr && hit_istat;
   assign wr_imask = reg_wr && hit_imask;
   // Per-port inputs gathered so that one loop serves both ports
   wire [`BPT_PORTS-1:0] clk_en_v;
   wire [`BPT_PORTS-1:0] queued_v;
   wire [`BPT_PORTS-1:0] repeat_v;
   wire [`BPT_PORTS*`BPT_TO_W-1:0] limit_v;
   wire [`BPT_PORTS-1:0] hit_v;
   assign clk_en_v = {sec_clk_en, pri_clk_en};
   assign queued_v = {sec_dc_queued, pri_dc_queued};
   assign repeat_v = {sec_repeat, pri_repeat};
   assign limit_v = {sec_to_r, pri_to_r};
   // Delayed transaction timers, one per port, counting that port's PCI clocks
   genvar g;
   generate
      for (g = 0; g < `BPT_PORTS; g = g + 1)
      begin : port_tmr
         reg [`BPT_TO_W-1:0] cnt_r;
         reg run_r;
         wire [`BPT_TO_W-1:0] limit;
         wire [`BPT_TO_W-1:0] cnt_inc;
         assign limit = limit_v[g*`BPT_TO_W +: `BPT_TO_W];
         // Never wraps; a limit of all ones is still reached one step earlier
         assign cnt_inc = cnt_r + `BPT_ONE16;
         // Expiry only on a PCI clock, and a repeat in that cycle saves the completion
         assign hit_v[g] = run_r && clk_en_v[g] && !repeat_v[g] && (cnt_inc >= limit);
         // Queue restarts the count and beats a repeat; repeat or expiry stops it
         always @(posedge clk_sys or negedge arst_n)
         begin
            if (!arst_n)
            begin
               cnt_r <= {`BPT_TO_W{1'b0}};
               run_r <= 1'b0;
            end
            else if (queued_v[g])
            begin
               run_r <= 1'b1;
               cnt_r <= {`BPT_TO_W{1'b0}};
            end
            else if (repeat_v[g] || hit_v[g])
            begin
               run_r <= 1'b0;
               cnt_r <= {`BPT_TO_W{1'b0}};
            end
            else if (run_r && clk_en_v[g])
               cnt_r <= cnt_inc;
         end
      end
   endgenerate
   // Option and timeout registers; upper option bits are not stored so writes vanish
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         opt_r <= `BPT_OPT_RESET;
         pri_to_r <= `BPT_TO_RESET;
         sec_to_r <= `BPT_TO_RESET;
         irq_mask_r <= {`BPT_IRQ_W{1'b0}};
      end
      else
      begin
         if (wr_opt)
            opt_r <= reg_wdata[`BPT_OPT_HI:`BPT_OPT_LO];
         if (wr_to)
         begin
            pri_to_r <= reg_wdata[`BPT_PTO_HI:`BPT_PTO_LO];
            sec_to_r <= reg_wdata[`BPT_STO_HI:`BPT_STO_LO];
         end
         if (wr_imask)
            irq_mask_r <= reg_wdata[`BPT_IRQ_W-1:0];
      end
   end
   // Control outputs registered from the option bits
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pri_mwi_keep <= 1'b0;
         sec_mwi_keep <= 1'b0;
         long_lock_req <= 1'b0;
         sec_hold_req <= 1'b1;
         pri_hold_req <= 1'b1;
      end
      else
      begin
         pri_mwi_keep <= opt_r[`BPT_BIT_PRI_MWI];
         sec_mwi_keep <= opt_r[`BPT_BIT_SEC_MWI];
         long_lock_req <= opt_r[`BPT_BIT_LONG_LOCK];
         sec_hold_req <= opt_r[`BPT_BIT_SEC_HOLD];
         pri_hold_req <= opt_r[`BPT_BIT_PRI_HOLD];
      end
   end
   // Discard pulses, one cycle after the expiring PCI clock
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pri_discard <= 1'b0;
         sec_discard <= 1'b0;
      end
      else
      begin
         pri_discard <= hit_v[`BPT_PRI];
         sec_discard <= hit_v[`BPT_SEC];
      end
   end
   // Timeout flag next value; a new timeout wins over a clear in the same cycle
   always @*
   begin
      dto_nxt = dto_r;
      if (|hit_v)
         dto_nxt = 1'b1;
      else if (wr_serr && reg_wdata[`BPT_BIT_DTO])
         dto_nxt = 1'b0;
   end
   // Interrupt status next value, write one to clear, set wins
   always @*
   begin
      irq_stat_nxt = irq_stat_r;
      if (wr_istat)
         irq_stat_nxt = irq_stat_r & ~reg_wdata[`BPT_IRQ_W-1:0];
      irq_stat_nxt = irq_stat_nxt | hit_v;
   end
   // Status flops
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dto_r <= 1'b0;
         irq_stat_r <= {`BPT_IRQ_W{1'b0}};
      end
      else
      begin
         dto_r <= dto_nxt;
         irq_stat_r <= irq_stat_nxt;
      end
   end
   // Level outputs lag their sources one cycle so that both leave a flop
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         primary_system_error_out <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         primary_system_error_out <= dto_r && serr_enable;
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end
   // Read mux; unmapped addresses and idle cycles give zero
   always @*
   begin
      rdata_nxt = `BPT_ZERO32;
      if (reg_rd)
      begin
         case (reg_addr)
            `BPT_OFF_PORT_OPT:
               rdata_nxt[`BPT_OPT_HI:`BPT_OPT_LO] = opt_r;
            `BPT_OFF_TIMEOUT:
            begin
               rdata_nxt[`BPT_PTO_HI:`BPT_PTO_LO] = pri_to_r;
               rdata_nxt[`BPT_STO_HI:`BPT_STO_LO] = sec_to_r;
            end
            `BPT_OFF_CAP_HDR:
            begin
               rdata_nxt[`BPT_CAP_HI:`BPT_CAP_LO] = `BPT_CAP_ID;
               rdata_nxt[`BPT_NXT_HI:`BPT_NXT_LO] = `BPT_NEXT_PTR;
            end
            `BPT_OFF_SERR_STAT:
               rdata_nxt[`BPT_BIT_DTO] = dto_r;
            `BPT_OFF_IRQ_STAT:
               rdata_nxt[`BPT_IRQ_W-1:0] = irq_stat_r;
            `BPT_OFF_IRQ_MASK:
               rdata_nxt[`BPT_IRQ_W-1:0] = irq_mask_r;
            default:
               rdata_nxt = `BPT_ZERO32;
         endcase
      end
   end
   // Read data stands only in the cycle after the strobe
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= `BPT_ZERO32;
      else
         reg_rdata <= rdata_nxt;
   end
endmodule

// ---- inc/bpt_consts.vh ----
// Constants for the bridge port option, master timeout and capability header registers
`ifndef BPT_CONSTS_VH
`define BPT_CONSTS_VH
`define BPT_AW 8
`define BPT_OFF_PORT_OPT 8'h74
`define BPT_OFF_TIMEOUT 8'h80
`define BPT_OFF_CAP_HDR 8'hDC
`define BPT_OFF_IRQ_STAT 8'hF0
`define BPT_OFF_IRQ_MASK 8'hF4
`define BPT_OFF_SERR_STAT 8'hF8
`define BPT_BIT_PRI_MWI 7
`define BPT_BIT_SEC_MWI 8
`define BPT_BIT_LONG_LOCK 9
`define BPT_BIT_SEC_HOLD 10
`define BPT_BIT_PRI_HOLD 11
`define BPT_BIT_DTO 23
`define BPT_OPT_LO 7
`define BPT_OPT_HI 11
`define BPT_OPT_RESET 5'h18
`define BPT_TO_W 16
`define BPT_PORTS 2
`define BPT_PRI 0
`define BPT_SEC 1
`define BPT_PTO_HI 15
`define BPT_PTO_LO 0
`define BPT_STO_HI 31
`define BPT_STO_LO 16
`define BPT_CAP_HI 7
`define BPT_CAP_LO 0
`define BPT_NXT_HI 15
`define BPT_NXT_LO 8
`define BPT_TO_RESET 16'h8000
`define BPT_CAP_ID 8'h01
`define BPT_NEXT_PTR 8'h00
`define BPT_ZERO32 32'h0000_0000
`define BPT_ZERO16 16'h0000
`define BPT_ONE16 16'h0001
`define BPT_IRQ_W 2
`endif

// ---- verif/bpt_pci_side.sv ----
// Far-side pacing: PCI clock enables of both ports
`timescale 1ns/1ps
module bpt_pci_side
(
   input wire clk_sys, // System clock
   input wire arst_n, // Reset, active low
   output logic [1:0] clk_en // Enables, secondary and primary
);
   logic [3:0] cnt_r;
   // PCI clocks are slower than clk_sys: primary 1 in 3, secondary 1 in 4
   always @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         {cnt_r, clk_en} <= 6'h00;
      else
      begin
         cnt_r <= (cnt_r == 4'hB) ? 4'h0 : cnt_r + 4'h1;
         clk_en <= {cnt_r[1:0] == 2'h3, cnt_r % 3 == 0};
      end
endmodule

// ---- verif/bpt_regs_assertions.sv ----
// Port-level checker for the option, timeout and capability slice
`timescale 1ns/1ps
`include "bpt_consts.vh"
module bpt_regs_chk
(
   input wire clk_sys, arst_n, reg_wr, reg_rd, serr_enable, pri_clk_en, sec_clk_en,
   input wire pri_dc_queued, pri_repeat, sec_dc_queued, sec_repeat,
   input wire [`BPT_AW-1:0] reg_addr,
   input wire [31:0] reg_wdata, reg_rdata,
   input wire pri_mwi_keep, sec_mwi_keep, long_lock_req, sec_hold_req, pri_hold_req,
   input wire pri_discard, sec_discard, primary_system_error_out, irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Option write lands, then the pins follow one edge later
   sequence opt_write_s;
      reg_wr && reg_addr == `BPT_OFF_PORT_OPT;
   endsequence
   opt_pins_a: assert property (opt_write_s ##2 1 |->
      {pri_hold_req, sec_hold_req, long_lock_req, sec_mwi_keep, pri_mwi_keep}
      == $past(reg_wdata[11:7], 2)) else $error("option pins wrong");
   rsvd_zero_a: assert property (reg_rd && reg_addr == `BPT_OFF_PORT_OPT |=>
      reg_rdata[15:12] == 4'h0) else $error("reserved bits not zero");
   cap_read_a: assert property (reg_rd && reg_addr == `BPT_OFF_CAP_HDR |=>
      reg_rdata == 32'h0000_0001) else $error("capability header wrong");
   pri_disc_a: assert property (pri_discard |-> $past(pri_clk_en) && !$past(pri_repeat))
      else $error("primary discard without clock");
   sec_disc_a: assert property (sec_discard |-> $past(sec_clk_en) && !$past(sec_repeat))
      else $error("secondary discard without clock");
   rep_stop_a: assert property (pri_repeat && !pri_dc_queued |=> !pri_discard)
      else $error("discard after repeat");
   serr_gate_a: assert property (primary_system_error_out |-> $past(serr_enable))
      else $error("system error while disabled");
   serr_raise_a: assert property ((pri_discard || sec_discard) && serr_enable |=>
      primary_system_error_out) else $error("system error missing");
endmodule
bind bpt_regs bpt_regs_chk chk (.*);

// ---- verif/test_bpt_regs.sv ----
// Self-checking bench for the option, timeout and capability slice
`timescale 1ns/1ps
`include "bpt_consts.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_bpt_regs;
   logic clk_sys = 0, arst_n, reg_wr = 0, reg_rd = 0, serr_enable = 1;
   logic [7:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, d;
   logic [1:0] q = 0, r = 0, ce, disc, hold;
   logic pmwi, smwi, lock, serr, irq;
   int failures = 0, checks = 0, n, i, m, opt = 32'h0000_0C00;
   int exp_q[$];
   wire [4:0] outs = {hold[0], hold[1], lock, smwi, pmwi};
   initial forever #2 clk_sys = ~clk_sys;
   bpt_pci_side far (.clk_sys, .arst_n, .clk_en(ce));
   bpt_regs uut (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .serr_enable,
      .pri_clk_en(ce[0]), .sec_clk_en(ce[1]), .pri_dc_queued(q[0]), .pri_repeat(r[0]),
      .sec_dc_queued(q[1]), .sec_repeat(r[1]), .reg_rdata, .pri_mwi_keep(pmwi),
      .sec_mwi_keep(smwi), .long_lock_req(lock), .sec_hold_req(hold[1]),
      .pri_hold_req(hold[0]), .pri_discard(disc[0]), .sec_discard(disc[1]),
      .primary_system_error_out(serr), .irq);
   task automatic results;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // One-cycle strobes, released at the next edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Queue a completion away from a clock enable, count enables until discard
   task automatic tr(input int p, input int lim, input bit rep);
      for (i = 0; i < 9; i++)
      begin
         @(posedge clk_sys);
         #1 if (ce[p]) break;
      end
      `CHK("enable seen", 1'b1, i < 9)
      if (i == 9)
         results();
      @(posedge clk_sys) q[p] <= 1'b1;
      @(posedge clk_sys) q[p] <= 1'b0;
      r[p] <= rep;
      n = 0;
      for (i = 0; i < 200; i++)
      begin
         #1 if (disc[p]) break;
         n += ce[p];
         @(posedge clk_sys) r[p] <= 1'b0;
      end
      `CHK("discard", !rep, i < 200)
      if (i == 200 && !rep)
         results();
      if (!rep)
      begin
         `CHK("pci clocks", lim, n)
         @(posedge clk_sys);
         #1 `CHK("irq", p == 0, irq)
         rd(`BPT_OFF_IRQ_STAT);
         `CHK("irq status", 1 << p, d & 3)
         `CHK("system error", serr_enable, serr)
         rd(`BPT_OFF_SERR_STAT);
         `CHK("timeout status", 32'h0080_0000, d)
         wr(`BPT_OFF_IRQ_STAT, 1 << p);
         wr(`BPT_OFF_SERR_STAT, 32'h0080_0000);
         repeat (2) @(posedge clk_sys);
         #1 `CHK("irq clear", 1'b0, irq | serr)
      end
   endtask
   initial
   begin
      arst_n <= 1'b0;
      n = $urandom(48);
      repeat (4) @(posedge clk_sys);
      `CHK("reset pins", opt[11:7], outs)
      arst_n <= 1'b1;
      rd(`BPT_OFF_TIMEOUT);
      `CHK("timeout reset", 32'h8000_8000, d)
      for (int k = 0; k < 6; k++)
      begin
         d = $urandom | 32'h0000_F000;
         wr(`BPT_OFF_PORT_OPT, d);
         opt = d & 32'h0000_0F80;
         rd(`BPT_OFF_PORT_OPT);
         `CHK("option", opt, d & 32'h0000_FF80)
         `CHK("option pins", opt[11:7], outs)
         n = $urandom;
         wr(`BPT_OFF_TIMEOUT, n);
         exp_q.push_back(n);
         wr(`BPT_OFF_CAP_HDR, n);
         rd(`BPT_OFF_TIMEOUT);
         m = exp_q.pop_front();
         `CHK("timeout", m, d)
         rd(`BPT_OFF_CAP_HDR);
         `CHK("capability", 32'h0000_0001, d)
         rd(8'h40);
         `CHK("unmapped", 32'h0000_0000, d)
      end
      wr(`BPT_OFF_TIMEOUT, 32'h0002_0003);
      wr(`BPT_OFF_IRQ_MASK, 32'h0000_0001);
      tr(0, 3, 0);
      @(posedge clk_sys) serr_enable <= 1'b0;
      tr(1, 2, 0);
      tr(0, 3, 1);
      results();
   end
endmodule
